// ==== core/mau_pkg.sv ====
package mau_pkg;
  // ****************************************
  // Program space
  // ****************************************
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_SHIFT = 3;
  // ****************************************
  // External data map
  // ****************************************
  localparam logic [15:0] GEN_LO = 16'h0000;
  localparam logic [15:0] GEN_HI = 16'h07FF;
  localparam logic [15:0] EDR_LO = 16'h1000;
  localparam logic [15:0] EDR_HI = 16'h13FF;
  localparam logic [15:0] PCR_LO = 16'h2000;
  localparam logic [15:0] PCR_HI = 16'h20FF;
  localparam logic [15:0] EPR_LO = 16'h3000;
  localparam logic [15:0] EPR_HI = 16'h3FFF;
  localparam int SEL_GEN = 0;
  localparam int SEL_EDR = 1;
  localparam int SEL_PCR = 2;
  localparam int SEL_EPR = 3;
  // ****************************************
  // External cycle timing
  // ****************************************
  localparam logic [2:0] STRETCH_RST = 3'h1;
  localparam logic [3:0] WR_SETUP = 4'h1;
  localparam logic [3:0] WR_EXTRA = 4'h1;
  // ****************************************
  // Special function area
  // ****************************************
  localparam logic [7:0] SFR_PTR0_LO = 8'h82;
  localparam logic [7:0] SFR_PTR0_HI = 8'h83;
  localparam logic [7:0] SFR_PTR1_LO = 8'h84;
  localparam logic [7:0] SFR_PTR1_HI = 8'h85;
  localparam logic [7:0] SFR_STRETCH = 8'h8E;
  localparam logic [7:0] SFR_PSEL = 8'h92;
  localparam logic [7:0] SFR_PAGE = 8'hBF;
  localparam logic [7:0] SFR_PSW = 8'hD0;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam int PSW_BANK_LSB = 3;
  localparam int AREA_BIT = 7;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;

  typedef enum logic {mau_idle, mau_active} mau_xstate_e;

  function automatic logic [3:0] mau_decode(input logic [15:0] a);
    logic [3:0] s;
    s = 4'h0;
    s[SEL_GEN] = a <= GEN_HI;
    s[SEL_EDR] = a >= EDR_LO && a <= EDR_HI;
    s[SEL_PCR] = a >= PCR_LO && a <= PCR_HI;
    s[SEL_EPR] = a >= EPR_LO && a <= EPR_HI;
    return s;
  endfunction
endpackage

// ==== core/mau_xbus_if.sv ====
`timescale 1ns/1ns
interface mau_xbus_if;
  logic start;
  logic write;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [2:0] stretch;
  logic en;
  logic [7:0] rdata;
  logic busy;
  logic done;
  logic [15:0] mem_addr;
  logic mem_rd;
  logic mem_wr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  modport ctrl(output start, write, addr, wdata, stretch, en, mem_rdata,
               input rdata, busy, done, mem_addr, mem_rd, mem_wr, mem_wdata);
  modport seq(input start, write, addr, wdata, stretch, en, mem_rdata,
              output rdata, busy, done, mem_addr, mem_rd, mem_wr, mem_wdata);
endinterface

// ==== core/mau_ext_cycle.sv ====
`timescale 1ns/1ns
module mau_ext_cycle import mau_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sequencer side of the external bus
  mau_xbus_if.seq bus
);
  mau_xstate_e state, next_state;
  logic [3:0] cnt, next_cnt, last, wr_len;
  logic [2:0] stretch_q, next_stretch;
  logic write_q, next_write, done_q, next_done;
  logic [15:0] addr_q, next_addr;
  logic [7:0] wdata_q, next_wdata, rdata_q, next_rdata;
  logic active, mapped, rd_int, wr_int;

  assign active = state == mau_active;
  assign last = write_q ? 4'(stretch_q) + WR_EXTRA : 4'(stretch_q);
  assign wr_len = (stretch_q < 3'h2) ? 4'h1 : 4'(stretch_q);
  assign mapped = |mau_decode(addr_q);
  assign rd_int = active && !write_q;
  assign wr_int = active && write_q && cnt >= WR_SETUP && cnt < WR_SETUP + wr_len;
  // Strobes stay low outside the map, so the cycle length never changes
  assign bus.mem_rd = rd_int && mapped;
  assign bus.mem_wr = wr_int && mapped;
  assign bus.mem_addr = active ? addr_q : 16'h0000;
  assign bus.mem_wdata = wdata_q;
  assign bus.busy = active;
  assign bus.done = done_q;
  assign bus.rdata = rdata_q;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_stretch = stretch_q;
    next_write = write_q;
    next_addr = addr_q;
    next_wdata = wdata_q;
    next_rdata = rdata_q;
    next_done = 1'b0;
    if (!active && bus.start) begin
      next_state = mau_active;
      next_cnt = 4'h0;
      next_stretch = bus.stretch;
      next_write = bus.write;
      next_addr = bus.addr;
      next_wdata = bus.wdata;
    end else if (active && bus.en) begin
      if (cnt == last) begin
        next_state = mau_idle;
        next_done = 1'b1;
        if (!write_q) begin
          next_rdata = mapped ? bus.mem_rdata : 8'h00;
        end
      end else begin
        next_cnt = cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= mau_idle;
      cnt <= 4'h0;
      stretch_q <= STRETCH_RST;
      write_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      stretch_q <= next_stretch;
      write_q <= next_write;
      addr_q <= next_addr;
      wdata_q <= next_wdata;
      rdata_q <= next_rdata;
      done_q <= next_done;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [3:0] a_ticks, s_ticks;
  always_ff @(posedge clk) begin
    if (reset || !active) begin
      a_ticks <= 4'h0;
      s_ticks <= 4'h0;
    end else if (bus.en) begin
      a_ticks <= a_ticks + 4'h1;
      s_ticks <= s_ticks + 4'((rd_int || wr_int) ? 1 : 0);
    end
  end

  a_read_width: assert property (@(posedge clk) disable iff (reset)
    $fell(active) && !write_q |-> a_ticks == 4'(stretch_q) + 4'h1 && s_ticks == a_ticks)
    else $error("read phase or strobe length wrong");
  a_write_addr_len: assert property (@(posedge clk) disable iff (reset)
    $fell(active) && write_q |-> a_ticks == 4'(stretch_q) + 4'h2)
    else $error("write address phase length wrong");
  a_write_strobe_len: assert property (@(posedge clk) disable iff (reset)
    $fell(active) && write_q |-> s_ticks == wr_len)
    else $error("write strobe length wrong");
  a_write_only_acc: assert property (@(posedge clk) disable iff (reset)
    bus.mem_wr |-> write_q && !bus.mem_rd)
    else $error("write strobe outside a write move");
  a_unmapped_quiet: assert property (@(posedge clk) disable iff (reset)
    bus.mem_rd || bus.mem_wr |-> bus.mem_addr <= GEN_HI || (bus.mem_addr >= EDR_LO && bus.mem_addr <= EDR_HI)
      || (bus.mem_addr >= PCR_LO && bus.mem_addr <= PCR_HI) || (bus.mem_addr >= EPR_LO && bus.mem_addr <= EPR_HI))
    else $error("strobe on unpopulated address");
  c_read_slow: cover property (@(posedge clk) $fell(active) && !write_q && stretch_q == 3'h7);
  c_write_fast: cover property (@(posedge clk) $fell(active) && write_q && stretch_q == 3'h0);
endmodule

// ==== core/mau_iram.sv ====
`timescale 1ns/1ns
module mau_iram import mau_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic en,
  // Byte port
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // Bit port
  input wire logic bit_req,
  input wire logic bit_wr,
  input wire logic [6:0] bit_addr,
  input wire logic bit_wdata,
  output logic bit_rdata,
  // Working register peek for paged moves
  input wire logic [7:0] ri_addr,
  output logic [7:0] ri_data
);
  logic [7:0] mem [0:255];
  logic [7:0] next_rdata, bit_byte, byte_val;
  logic next_bit;

  assign bit_byte = BIT_AREA_BASE | {4'h0, bit_addr[6:3]};
  assign byte_val = mem[bit_byte];
  assign ri_data = mem[ri_addr];

  always_comb begin
    next_rdata = rdata;
    next_bit = bit_rdata;
    if (en && req && !wr) begin
      next_rdata = mem[addr];
    end
    if (en && bit_req) begin
      next_bit = byte_val[bit_addr[2:0]];
    end
  end

  // Byte write wins over a bit write in the same cycle
  always_ff @(posedge clk) begin
    if (en && req && wr) begin
      mem[addr] <= wdata;
    end else if (en && bit_req && bit_wr) begin
      mem[bit_byte][bit_addr[2:0]] <= bit_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
      bit_rdata <= 1'b0;
    end else begin
      rdata <= next_rdata;
      bit_rdata <= next_bit;
    end
  end
endmodule

// ==== core/mau_top.sv ====
`timescale 1ns/1ns
module mau_top import mau_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Clock rate
  input wire logic [2:0] cpu_clock_divider,
  output logic mpu_clk_en,
  // Program fetch
  input wire logic fetch_advance,
  input wire logic jump_req,
  input wire logic [15:0] jump_target,
  input wire logic intr_enter,
  input wire logic [2:0] intr_source,
  input wire logic cmove_req,
  input wire logic [15:0] cmove_addr,
  input wire logic [7:0] code_rdata,
  output logic [15:0] code_addr,
  output logic [15:0] program_counter,
  output logic [7:0] instr_byte,
  output logic [7:0] cmove_data,
  // Internal data
  input wire logic idata_req,
  input wire logic idata_wr,
  input wire logic idata_direct,
  input wire logic idata_wreg,
  input wire logic [7:0] idata_addr,
  input wire logic [7:0] idata_wdata,
  output logic [7:0] idata_rdata,
  input wire logic bit_req,
  input wire logic bit_wr,
  input wire logic [6:0] bit_addr,
  input wire logic bit_wdata,
  output logic bit_rdata,
  // Data pointer
  input wire logic ptr_inc,
  input wire logic ptr_load,
  input wire logic [15:0] ptr_load_value,
  output logic [15:0] data_pointer,
  // External move
  input wire logic xmov_req,
  input wire logic xmov_acc_src,
  input wire logic xmov_use_ptr,
  input wire logic xmov_ri_sel,
  input wire logic [7:0] acc_value,
  output logic xmov_busy,
  output logic xmov_done,
  output logic [7:0] xmov_rdata,
  // External memory bus
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic [3:0] mem_sel
);
  // ****************************************
  // State
  // ****************************************
  logic [2:0] div_cnt, next_div_cnt;
  logic [15:0] pc, next_pc, ptr0, next_ptr0, ptr1, next_ptr1, ptr_new;
  logic [7:0] next_instr, next_cmove, page, next_page, program_status_word, next_psw;
  logic [2:0] stretch, next_stretch;
  logic psel, next_psel, sfr_sel, next_sfr_sel;
  logic [7:0] sfr_rdata, next_sfr_rdata, sfr_read, iram_rdata, iram_addr;
  logic [7:0] ri_addr, ri_data;
  logic [1:0] bank;
  logic mpu_en, sfr_access, sfr_wr, iram_req;
  mau_xbus_if xbus();

  // ****************************************
  // Clock divider
  // ****************************************
  // Period is divider plus one; the count is compared with the live field, so a new value applies within the current period
  assign mpu_en = div_cnt == 3'h0;
  assign mpu_clk_en = mpu_en;
  always_comb begin
    next_div_cnt = (div_cnt >= cpu_clock_divider) ? 3'h0 : div_cnt + 3'h1;
  end

  // ****************************************
  // Address resolution
  // ****************************************
  assign bank = program_status_word[PSW_BANK_LSB +: 2];
  assign sfr_access = idata_req && idata_direct && !idata_wreg && idata_addr[AREA_BIT];
  assign sfr_wr = mpu_en && sfr_access && idata_wr;
  assign iram_req = idata_req && !sfr_access;
  assign iram_addr = idata_wreg ? {3'h0, bank, idata_addr[2:0]} : idata_addr;
  assign ri_addr = {3'h0, bank, 2'h0, xmov_ri_sel};
  assign data_pointer = psel ? ptr1 : ptr0;
  assign ptr_new = ptr_load ? ptr_load_value : data_pointer + 16'h0001;
  assign code_addr = cmove_req ? cmove_addr : pc;
  assign program_counter = pc;
  assign idata_rdata = sfr_sel ? sfr_rdata : iram_rdata;

  always_comb begin
    sfr_read = 8'h00;
    case (idata_addr)
      SFR_PTR0_LO: sfr_read = ptr0[7:0];
      SFR_PTR0_HI: sfr_read = ptr0[15:8];
      SFR_PTR1_LO: sfr_read = ptr1[7:0];
      SFR_PTR1_HI: sfr_read = ptr1[15:8];
      SFR_STRETCH: sfr_read = {5'h00, stretch};
      SFR_PSEL: sfr_read = {7'h00, psel};
      SFR_PAGE: sfr_read = page;
      SFR_PSW: sfr_read = program_status_word;
      default: sfr_read = 8'h00;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_pc = pc;
    next_instr = instr_byte;
    next_cmove = cmove_data;
    next_stretch = stretch;
    next_psel = psel;
    next_ptr0 = ptr0;
    next_ptr1 = ptr1;
    next_page = page;
    next_psw = program_status_word;
    next_sfr_sel = sfr_sel;
    next_sfr_rdata = sfr_rdata;
    if (mpu_en) begin
      if (cmove_req) begin
        next_cmove = code_rdata;
      end
      if (intr_enter) begin
        next_pc = VEC_BASE + (16'(intr_source) << VEC_SHIFT);
      end else if (jump_req) begin
        next_pc = jump_target;
      end else if (fetch_advance && !cmove_req) begin
        next_instr = code_rdata;
        next_pc = pc + 16'h0001;
      end
      if (ptr_load || ptr_inc) begin
        if (psel) begin
          next_ptr1 = ptr_new;
        end else begin
          next_ptr0 = ptr_new;
        end
      end
      if (idata_req) begin
        next_sfr_sel = sfr_access;
        if (sfr_access && !idata_wr) begin
          next_sfr_rdata = sfr_read;
        end
      end
      // A direct byte write lands after a pointer step in the same cycle
      if (sfr_wr) begin
        case (idata_addr)
          SFR_PTR0_LO: next_ptr0[7:0] = idata_wdata;
          SFR_PTR0_HI: next_ptr0[15:8] = idata_wdata;
          SFR_PTR1_LO: next_ptr1[7:0] = idata_wdata;
          SFR_PTR1_HI: next_ptr1[15:8] = idata_wdata;
          SFR_STRETCH: next_stretch = idata_wdata[2:0];
          SFR_PSEL: next_psel = idata_wdata[0];
          SFR_PAGE: next_page = idata_wdata;
          SFR_PSW: next_psw = idata_wdata;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      div_cnt <= 3'h0;
      pc <= PC_RESET;
      instr_byte <= 8'h00;
      cmove_data <= 8'h00;
      stretch <= STRETCH_RST;
      psel <= 1'b0;
      ptr0 <= PTR_RST;
      ptr1 <= PTR_RST;
      page <= 8'h00;
      program_status_word <= PSW_RST;
      sfr_sel <= 1'b0;
      sfr_rdata <= 8'h00;
    end else begin
      div_cnt <= next_div_cnt;
      pc <= next_pc;
      instr_byte <= next_instr;
      cmove_data <= next_cmove;
      stretch <= next_stretch;
      psel <= next_psel;
      ptr0 <= next_ptr0;
      ptr1 <= next_ptr1;
      page <= next_page;
      program_status_word <= next_psw;
      sfr_sel <= next_sfr_sel;
      sfr_rdata <= next_sfr_rdata;
    end
  end

  // ****************************************
  // Internal memory and external cycles
  // ****************************************
  mau_iram u_iram (
    .clk(clk),
    .reset(reset),
    .en(mpu_en),
    .req(iram_req),
    .wr(idata_wr),
    .addr(iram_addr),
    .wdata(idata_wdata),
    .rdata(iram_rdata),
    .bit_req(bit_req),
    .bit_wr(bit_wr),
    .bit_addr(bit_addr),
    .bit_wdata(bit_wdata),
    .bit_rdata(bit_rdata),
    .ri_addr(ri_addr),
    .ri_data(ri_data)
  );

  // Requests during a busy cycle are dropped; the core waits for done
  assign xbus.start = mpu_en && xmov_req && !xbus.busy;
  assign xbus.write = xmov_acc_src;
  assign xbus.addr = xmov_use_ptr ? data_pointer : {page, ri_data};
  assign xbus.wdata = acc_value;
  assign xbus.stretch = stretch;
  assign xbus.en = mpu_en;
  assign xbus.mem_rdata = mem_rdata;

  mau_ext_cycle u_ext (
    .clk(clk),
    .reset(reset),
    .bus(xbus.seq)
  );

  assign xmov_busy = xbus.busy;
  assign xmov_done = xbus.done;
  assign xmov_rdata = xbus.rdata;
  assign mem_addr = xbus.mem_addr;
  assign mem_rd = xbus.mem_rd;
  assign mem_wr = xbus.mem_wr;
  assign mem_wdata = xbus.mem_wdata;
  assign mem_sel = xbus.busy ? mau_decode(xbus.mem_addr) : 4'h0;

  // ****************************************
  // Checks
  // ****************************************
  a_reset_fetch: assert property (@(posedge clk) disable iff (reset)
    $past(reset) |-> pc == PC_RESET && (code_addr == PC_RESET || cmove_req))
    else $error("fetch does not start at zero");
  a_vector_place: assert property (@(posedge clk) disable iff (reset)
    mpu_en && intr_enter |=> pc == VEC_BASE + (16'($past(intr_source)) << VEC_SHIFT))
    else $error("interrupt entry misplaced");
  a_stretch_reset: assert property (@(posedge clk) disable iff (reset)
    $past(reset) |-> stretch == STRETCH_RST)
    else $error("stretch not one after reset");
  a_ptr_load_sel: assert property (@(posedge clk) disable iff (reset)
    mpu_en && ptr_load && !sfr_wr && !$changed(psel) |=> data_pointer == $past(ptr_load_value))
    else $error("selected pointer not loaded");
  a_other_ptr_kept: assert property (@(posedge clk) disable iff (reset)
    mpu_en && (ptr_inc || ptr_load) && !sfr_wr |=> (psel ? ptr0 : ptr1) == $past(psel ? ptr0 : ptr1))
    else $error("unselected pointer changed");
  a_page_addr: assert property (@(posedge clk) disable iff (reset)
    xbus.start && !xmov_use_ptr |=> mem_addr == {$past(page), $past(ri_data)})
    else $error("paged address wrong");
  a_ptr_addr: assert property (@(posedge clk) disable iff (reset)
    xbus.start && xmov_use_ptr |=> mem_addr == $past(data_pointer))
    else $error("pointer address wrong");
  a_decode_range: assert property (@(posedge clk) disable iff (reset)
    mem_sel[SEL_EPR] |-> mem_addr >= EPR_LO && mem_addr <= EPR_HI && $onehot(mem_sel))
    else $error("engine program select out of range");
  a_bank_regs: assert property (@(posedge clk) disable iff (reset)
    idata_req && idata_wreg |-> iram_addr[7:5] == 3'h0 && iram_addr[4:3] == bank)
    else $error("working register outside active bank");
  c_intr_entry: cover property (@(posedge clk) mpu_en && intr_enter && intr_source == 3'h5);
  c_ptr_swap: cover property (@(posedge clk) sfr_wr && idata_addr == SFR_PSEL);
  c_paged_read: cover property (@(posedge clk) xbus.start && !xmov_use_ptr && !xmov_acc_src);
endmodule

// ==== tb/mau_mem_model.sv ====
`timescale 1ns/1ns
module mau_mem_model (
  // Bus side
  input wire logic clk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  // Code side
  input wire logic [15:0] code_addr,
  output logic [7:0] code_rdata
);
  logic [7:0] ram [0:16'hFFFF];
  logic [7:0] last = 8'h00;
  function automatic logic pop(input logic [15:0] a);
    return a < 16'h0800 || a[15:10] == 6'h04 || a[15:8] == 8'h20 || a[15:12] == 4'h3;
  endfunction
  always @(posedge clk) begin
    if (mem_wr && pop(mem_addr)) ram[mem_addr] <= mem_wdata;
    last <= mem_rdata;
  end
  // Released bus flips so a stale byte cannot pass as good read data
  assign mem_rdata = (mem_rd && pop(mem_addr)) ? ram[mem_addr] : ~last;
  assign code_rdata = code_addr[7:0] ^ code_addr[15:8] ^ 8'h5A;
endmodule

// ==== tb/mau_top_tb_top.sv ====
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module mau_top_tb_top import mau_pkg::*;;
  // ****
  // Stimulus and checking
  // ****
  typedef struct {logic [15:0] a; logic [7:0] d; logic [3:0] s; logic r; int nb; int ns;} mau_exp_s;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [2:0] cpu_clock_divider, intr_source;
  logic fetch_advance, jump_req, intr_enter, cmove_req, idata_req, idata_wr, idata_direct, idata_wreg;
  logic bit_req, bit_wr, bit_wdata, ptr_inc, ptr_load, xmov_req, xmov_acc_src, xmov_use_ptr, xmov_ri_sel;
  logic mpu_clk_en, bit_rdata, xmov_busy, xmov_done, mem_rd, mem_wr;
  logic [15:0] jump_target, cmove_addr, code_addr, program_counter, ptr_load_value, data_pointer, mem_addr, fa, t, v0, v1;
  logic [7:0] code_rdata, instr_byte, cmove_data, idata_addr, idata_wdata, idata_rdata, acc_value, xmov_rdata;
  logic [7:0] mem_wdata, mem_rdata, hi, lo;
  logic [6:0] bit_addr;
  logic [3:0] mem_sel, fs;
  logic [7:0] shadow [logic [15:0]];
  logic [15:0] base [5] = '{16'h0000, 16'h1000, 16'h2000, 16'h3000, 16'h0800};
  logic [15:0] mask [5] = '{16'h07FF, 16'h03FF, 16'h00FF, 16'h0FFF, 16'h07FF};
  mau_exp_s q[$];
  int error_cnt = 0, checks_done = 0, i, n;
  // Four-state counters so an unknown strobe cannot pass as a quiet one
  logic [7:0] nb = 8'h00, ns = 8'h00;
  mau_top dut (.clk(clk), .reset(reset), .cpu_clock_divider(cpu_clock_divider), .mpu_clk_en(mpu_clk_en),
    .fetch_advance(fetch_advance), .jump_req(jump_req), .jump_target(jump_target), .intr_enter(intr_enter),
    .intr_source(intr_source), .cmove_req(cmove_req), .cmove_addr(cmove_addr), .code_rdata(code_rdata),
    .code_addr(code_addr), .program_counter(program_counter), .instr_byte(instr_byte), .cmove_data(cmove_data),
    .idata_req(idata_req), .idata_wr(idata_wr), .idata_direct(idata_direct), .idata_wreg(idata_wreg),
    .idata_addr(idata_addr), .idata_wdata(idata_wdata), .idata_rdata(idata_rdata), .bit_req(bit_req),
    .bit_wr(bit_wr), .bit_addr(bit_addr), .bit_wdata(bit_wdata), .bit_rdata(bit_rdata), .ptr_inc(ptr_inc),
    .ptr_load(ptr_load), .ptr_load_value(ptr_load_value), .data_pointer(data_pointer), .xmov_req(xmov_req),
    .xmov_acc_src(xmov_acc_src), .xmov_use_ptr(xmov_use_ptr), .xmov_ri_sel(xmov_ri_sel), .acc_value(acc_value),
    .xmov_busy(xmov_busy), .xmov_done(xmov_done), .xmov_rdata(xmov_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_sel(mem_sel));
  mau_mem_model mem (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .code_addr(code_addr), .code_rdata(code_rdata));
  always #50 clk = ~clk;
  function automatic logic [3:0] tsel(input logic [15:0] a);
    return {a[15:12] == 4'h3, a[15:8] == 8'h20, a[15:10] == 6'h04, a < 16'h0800};
  endfunction
  task step;
    @(posedge clk);
    #10;
  endtask
  task ida(input logic w, dir, wreg, input logic [7:0] a, d);
    idata_req = 1;
    {idata_wr, idata_direct, idata_wreg, idata_addr, idata_wdata} = {w, dir, wreg, a, d};
    step;
    idata_req = 0;
    // Idle edge so back-to-back accesses never glitch the request
    step;
  endtask
  task pl(input logic [15:0] v);
    ptr_load = 1;
    ptr_load_value = v;
    step;
    ptr_load = 0;
  endtask
  task xm(input logic w, ptr, input logic [15:0] a, input logic [7:0] d, input int s);
    mau_exp_s e;
    int k;
    e.a = a;
    e.r = !w;
    e.s = tsel(a);
    e.nb = w ? s + 2 : s + 1;
    e.ns = e.s == 0 ? 0 : (w ? (s > 1 ? s : 1) : s + 1);
    if (w && e.s != 0) shadow[a] = d;
    e.d = e.s == 0 ? 8'h00 : shadow[a];
    if (ptr) pl(a);
    q.push_back(e);
    {xmov_req, xmov_acc_src, xmov_use_ptr, acc_value} = {1'h1, w, ptr, d};
    step;
    xmov_req = 0;
    k = 0;
    while (xmov_done !== 1'h1 && k < 40) begin
      step;
      k++;
    end
    if (k == 40) error_cnt++;
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Busy, strobe and address are sampled mid-cycle, well clear of the edges
  always @(negedge clk) begin
    if (xmov_busy === 1'h1) begin
      if (nb == 0) {fa, fs} = {mem_addr, mem_sel};
      nb++;
      ns += {7'h00, mem_rd | mem_wr};
    end
    if (xmov_done === 1'h1 && q.size() > 0) begin
      `CHK("addr", q[0].a, fa)
      `CHK("sel", q[0].s, fs)
      `CHK("busy", q[0].nb, nb)
      `CHK("strobe", q[0].ns, ns)
      if (q[0].r) `CHK("rdata", q[0].d, xmov_rdata)
      void'(q.pop_front());
      {nb, ns} = '0;
    end
  end
  initial begin
    #4000000;
    error_cnt++;
    complete_run;
  end
  initial begin
    {cpu_clock_divider, intr_source, fetch_advance, jump_req, intr_enter, cmove_req, idata_req, bit_req} = '0;
    {ptr_inc, ptr_load, xmov_req, xmov_acc_src, xmov_use_ptr, xmov_ri_sel, bit_wr, bit_wdata, bit_addr} = '0;
    {jump_target, cmove_addr, idata_wr, idata_direct, idata_wreg, idata_addr, idata_wdata, ptr_load_value, acc_value} = '0;
    void'($urandom(32'h984c_e033));
    repeat (3) step;
    reset = 0;
    `CHK("pc", 16'h0000, program_counter)
    fetch_advance = 1;
    step;
    fetch_advance = 0;
    `CHK("ibyte", 8'h5A, instr_byte)
    `CHK("pc1", 16'h0001, program_counter)
    for (i = 0; i < 8; i++) begin
      {intr_enter, intr_source} = {1'h1, 3'(i)};
      step;
      `CHK("vec", 16'h0003 + 16'(8 * i), program_counter)
    end
    intr_enter = 0;
    t = 16'($urandom);
    {jump_req, jump_target, cmove_req, cmove_addr} = {1'h1, t, 1'h1, ~t};
    step;
    {jump_req, cmove_req} = '0;
    `CHK("cmove", t[7:0] ^ t[15:8] ^ 8'h5A, cmove_data)
    $display("program space test done");
    v0 = 16'($urandom);
    v1 = 16'($urandom);
    ida(1, 1, 0, SFR_PSEL, 8'h00);
    pl(v0);
    ida(1, 1, 0, SFR_PSEL, 8'h01);
    pl(v1);
    `CHK("secondary_data_pointer", v1, data_pointer)
    ida(1, 1, 0, SFR_PSEL, 8'h00);
    ptr_inc = 1;
    step;
    ptr_inc = 0;
    `CHK("dptr0", v0 + 16'h0001, data_pointer)
    ida(0, 1, 0, SFR_PTR1_HI, 8'h00);
    `CHK("dptr1hi", v1[15:8], idata_rdata)
    $display("pointer test done");
    t = 16'($urandom) & 16'h07FF;
    xm(1, 1, t, 8'($urandom), 1);
    xm(0, 1, t, 8'h00, 1);
    for (i = 0; i < 8; i++) begin
      ida(1, 1, 0, SFR_STRETCH, {5'h1F, 3'(i)});
      ida(0, 1, 0, SFR_STRETCH, 8'h00);
      `CHK("stretch", 8'(i), idata_rdata)
      t = base[i % 5] | (16'($urandom) & mask[i % 5]);
      xm(1, 1, t, 8'($urandom), i);
      xm(0, 1, t, 8'h00, i);
    end
    {hi, lo} = 16'($urandom);
    ida(1, 1, 0, SFR_PSW, 8'h10);
    ida(1, 0, 1, 8'h01, lo);
    ida(0, 1, 0, 8'h11, 8'h00);
    `CHK("bank", lo, idata_rdata)
    ida(1, 1, 0, SFR_PAGE, hi);
    xmov_ri_sel = 1;
    xm(1, 0, {hi, lo}, 8'($urandom), 7);
    xm(0, 0, {hi, lo}, 8'h00, 7);
    $display("external move test done");
    ida(1, 0, 0, 8'h2F, 8'h00);
    {bit_req, bit_wr, bit_addr, bit_wdata} = {1'h1, 1'h1, 7'h7F, 1'h1};
    step;
    bit_wr = 0;
    step;
    bit_req = 0;
    `CHK("bit", 1'h1, bit_rdata)
    ida(0, 1, 0, 8'h2F, 8'h00);
    `CHK("bitbyte", 8'h80, idata_rdata)
    ida(1, 0, 0, 8'h90, lo);
    ida(0, 0, 0, 8'h90, 8'h00);
    `CHK("upper", lo, idata_rdata)
    ida(0, 1, 0, 8'h90, 8'h00);
    `CHK("sfrgap", 8'h00, idata_rdata)
    cpu_clock_divider = 3'h2;
    step;
    n = 0;
    repeat (9) begin
      step;
      n += int'(mpu_clk_en);
    end
    `CHK("div", 3, n)
    $display("internal memory and divider test done");
    complete_run;
  end
endmodule
